/* rtl/nfiu_pkg.sv */
// package of the frontend interrupt unit: register map, bit positions, state types
// assumes a single system clock and a byte-wide internal register port
package nfiu_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] NFIU_ADDR_REQ0 = 8'h06;
	localparam logic [7:0] NFIU_ADDR_REQ1 = 8'h07;
	localparam logic [7:0] NFIU_ADDR_EN0  = 8'h08;
	localparam logic [7:0] NFIU_ADDR_EN1  = 8'h09;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int NFIU_BIT_SET_SEL   = 7;
	localparam int NFIU_BIT_HI_ALERT  = 6;
	localparam int NFIU_BIT_LO_ALERT  = 5;
	localparam int NFIU_BIT_IDLE      = 4;
	localparam int NFIU_BIT_TX_DONE   = 3;
	localparam int NFIU_BIT_RX_DONE   = 2;
	localparam int NFIU_BIT_ERR_SUM   = 1;
	localparam int NFIU_BIT_SOF       = 0;
	localparam int NFIU_BIT_GLOBAL    = 6;
	localparam int NFIU_BIT_CARD      = 5;
	localparam int NFIU_BIT_PIN_INV   = 7;
	localparam int NFIU_BIT_PUSH_PULL = 7;
	localparam int NFIU_BIT_PIN_EN    = 6;
	localparam int NFIU_NUM_TIMERS    = 5;
	localparam int NFIU_NUM_ERRORS    = 5;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] NFIU_RST_REQ0 = 8'h00;
	localparam logic [5:0] NFIU_RST_REQ1 = 6'h00;
	localparam logic [7:0] NFIU_RST_EN0  = 8'h00;
	localparam logic [7:0] NFIU_RST_EN1  = 8'h00;
	localparam logic [7:0] NFIU_RST_RD   = 8'h00;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} nfiu_reg_req_s;

	// event sources of the frontend
	typedef struct packed {
		logic       cmd_self_end;
		logic       cmd_unknown;
		logic       host_idle_start;
		logic       tx_last_bit;
		logic       rx_end;
		logic [4:0] errors;
		logic       sof_det;
		logic       subcarrier_det;
		logic       fifo_hi_alert;
		logic       fifo_lo_alert;
		logic       card_detect;
		logic [4:0] timer_underflow;
	} nfiu_events_s;

	// main state
	typedef struct packed {
		logic [6:0] req0;
		logic [5:0] req1;
		logic [7:0] en0;
		logic [7:0] en1;
		logic [4:0] err_prev;
		logic [7:0] rdata;
	} nfiu_state_s;

	// pin driver state
	typedef struct packed {
		logic pin;
		logic oe_n;
	} nfiu_pin_s;

endpackage

/* rtl/nfiu_pin_drv.sv */
// interrupt pin driver: polarity, gating and push-pull or open-drain drive
// assumes its control inputs come from registers on the same clock
module nfiu_pin_drv (
	input  wire logic sys_clk_i,    // system clock
	input  wire logic rst_i,        // async reset, active high
	input  wire logic global_i,     // global request level
	input  wire logic pin_en_i,     // gate request onto pin
	input  wire logic invert_i,     // invert pin polarity
	input  wire logic push_pull_i,  // 1 push-pull, 0 open-drain
	output logic      irq_pin_o,    // pin output value
	output logic      irq_oe_n_o    // pin output enable, low drives
);
	import nfiu_pkg::*;

	nfiu_pin_s q;
	nfiu_pin_s d;
	logic      level;

	always_comb begin
		// inactive level follows polarity when gated off
		level = (global_i & pin_en_i) ^ invert_i;
		d.pin = level;
		// open-drain only pulls low, releases for high
		d.oe_n = push_pull_i ? 1'b0 : level;
		if (!push_pull_i) begin
			d.pin = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign irq_pin_o  = q.pin;
	assign irq_oe_n_o = q.oe_n;

	AST_OPEN_DRAIN_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!push_pull_i |=> irq_pin_o == 1'b0)
		else $error("open-drain pin driven high");

endmodule

/* rtl/nfiu_irq_unit.sv */
// interrupt request and enable logic of the contactless frontend
// assumes event inputs come from logic on sys_clk_i and register port is synchronous
module nfiu_irq_unit (
	input  wire logic                    sys_clk_i,   // system clock, 200 MHz
	input  wire logic                    rst_i,       // async reset, active high
	input  wire nfiu_pkg::nfiu_reg_req_s reg_req_i,   // register write/read request
	output logic [7:0]                   reg_rdata_o, // read data, one cycle after rd
	input  wire nfiu_pkg::nfiu_events_s  events_i,    // frontend event sources
	output logic                         global_o,    // global request level
	output logic                         irq_pin_o,   // interrupt pin value
	output logic                         irq_oe_n_o   // interrupt pin enable, low drives
);
	import nfiu_pkg::*;

	// ------------------------------------------------------------
	// write-one set/clear helper
	// ------------------------------------------------------------
	function automatic logic [6:0] apply_w1(input logic [6:0] cur, input logic [7:0] wdata,
	                                        input logic hit);
		logic [6:0] res;
		res = cur;
		if (hit) begin
			if (wdata[NFIU_BIT_SET_SEL]) begin
				res = cur | wdata[6:0];
			end else begin
				res = cur & ~wdata[6:0];
			end
		end
		return res;
	endfunction

	// write strobe decode, shared by every writable register
	function automatic logic wr_hit(input nfiu_reg_req_s req, input logic [7:0] addr);
		return req.wr && (req.addr == addr);
	endfunction

	nfiu_state_s q;
	nfiu_state_s d;
	logic [6:0]  hw0;
	logic [5:0]  hw1;
	logic [6:0]  req1_ext;
	logic        wr0;
	logic        wr1;
	logic        global_req;

	// ------------------------------------------------------------
	// global request
	// ------------------------------------------------------------
	assign global_req = (|(q.req0 & q.en0[6:0])) |
	                    (|(q.req1 & q.en1[5:0]));

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		wr0 = wr_hit(reg_req_i, NFIU_ADDR_REQ0);
		wr1 = wr_hit(reg_req_i, NFIU_ADDR_REQ1);

		hw0 = '0;
		// host_idle_start deliberately sets nothing
		hw0[NFIU_BIT_IDLE]     = events_i.cmd_self_end | events_i.cmd_unknown;
		hw0[NFIU_BIT_TX_DONE]  = events_i.tx_last_bit;
		hw0[NFIU_BIT_RX_DONE]  = events_i.rx_end;
		hw0[NFIU_BIT_ERR_SUM]  = |(events_i.errors & ~q.err_prev);
		hw0[NFIU_BIT_SOF]      = events_i.sof_det | events_i.subcarrier_det;
		hw0[NFIU_BIT_HI_ALERT] = events_i.fifo_hi_alert;
		hw0[NFIU_BIT_LO_ALERT] = events_i.fifo_lo_alert;

		hw1 = '0;
		hw1[NFIU_BIT_CARD]             = events_i.card_detect;
		hw1[NFIU_NUM_TIMERS-1:0]       = events_i.timer_underflow;

		// hardware set applied after host write so it wins
		d.req0 = apply_w1(q.req0, reg_req_i.wdata, wr0) | hw0;
		req1_ext = apply_w1({1'b0, q.req1}, {reg_req_i.wdata[7:6] & 2'h2, reg_req_i.wdata[5:0]}, wr1);
		d.req1 = req1_ext[5:0] | hw1;
		d.err_prev = events_i.errors;

		if (wr_hit(reg_req_i, NFIU_ADDR_EN0)) begin
			d.en0 = reg_req_i.wdata;
		end
		if (wr_hit(reg_req_i, NFIU_ADDR_EN1)) begin
			d.en1 = reg_req_i.wdata;
		end

		if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				NFIU_ADDR_REQ0: d.rdata = {1'b0, q.req0};
				NFIU_ADDR_REQ1: d.rdata = {1'b0, global_req, q.req1};
				NFIU_ADDR_EN0:  d.rdata = q.en0;
				NFIU_ADDR_EN1:  d.rdata = q.en1;
				default:        d.rdata = NFIU_RST_RD;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q.req0     <= NFIU_RST_REQ0[6:0];
			q.req1     <= NFIU_RST_REQ1;
			q.en0      <= NFIU_RST_EN0;
			q.en1      <= NFIU_RST_EN1;
			q.err_prev <= '0;
			q.rdata    <= NFIU_RST_RD;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign global_o    = global_req;

	// ------------------------------------------------------------
	// pin driver
	// ------------------------------------------------------------
	nfiu_pin_drv u_pin (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.global_i    (global_req),
		.pin_en_i    (q.en1[NFIU_BIT_PIN_EN]),
		.invert_i    (q.en0[NFIU_BIT_PIN_INV]),
		.push_pull_i (q.en1[NFIU_BIT_PUSH_PULL]),
		.irq_pin_o   (irq_pin_o),
		.irq_oe_n_o  (irq_oe_n_o)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_IDLE_SELF_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.cmd_self_end |=> q.req0[NFIU_BIT_IDLE])
		else $error("idle flag not set on command end");

	AST_IDLE_UNKNOWN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.cmd_unknown |=> q.req0[NFIU_BIT_IDLE])
		else $error("idle flag not set on unknown command");

	AST_IDLE_HOST_START: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(events_i.host_idle_start && !events_i.cmd_self_end && !events_i.cmd_unknown
		 && !q.req0[NFIU_BIT_IDLE] && !wr0) |=> !q.req0[NFIU_BIT_IDLE])
		else $error("host idle start set idle flag");

	AST_REQ0_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!wr0 && hw0 == 7'h00)
		|=> q.req0 == $past(q.req0))
		else $error("request zero changed without cause");

	AST_TX_DONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.tx_last_bit |=> q.req0[NFIU_BIT_TX_DONE])
		else $error("transmit-done flag missing");

	AST_RX_DONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.rx_end |=> q.req0[NFIU_BIT_RX_DONE])
		else $error("receive-done flag missing");

	AST_ERR_SUMMARY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(|(events_i.errors & ~$past(events_i.errors))) |=> q.req0[NFIU_BIT_ERR_SUM])
		else $error("error summary flag missing");

	AST_ERR_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!(|(events_i.errors & ~q.err_prev)) && !wr0 && !q.req0[NFIU_BIT_ERR_SUM])
		|=> !q.req0[NFIU_BIT_ERR_SUM])
		else $error("error summary set without new error");

	AST_SOF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(events_i.sof_det || events_i.subcarrier_det) |=> q.req0[NFIU_BIT_SOF])
		else $error("start-of-frame flag missing");

	AST_REQ1_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr1 && !reg_req_i.wdata[NFIU_BIT_SET_SEL] && reg_req_i.wdata[0]
		 && !events_i.timer_underflow[0]) |=> !q.req1[0])
		else $error("request one clear failed");

	AST_REQ1_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr1 && reg_req_i.wdata[NFIU_BIT_SET_SEL] && reg_req_i.wdata[NFIU_BIT_CARD])
		|=> q.req1[NFIU_BIT_CARD])
		else $error("request one set failed");

	AST_READ_SET_BIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(reg_req_i.rd && (reg_req_i.addr == NFIU_ADDR_REQ0 || reg_req_i.addr == NFIU_ADDR_REQ1))
		|=> !reg_rdata_o[NFIU_BIT_SET_SEL])
		else $error("set select bit read back as one");

	AST_REQ0_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr0 && reg_req_i.wdata == 8'hFF) |=> (q.req0 == 7'h7F))
		else $error("request zero set-all failed");

	AST_REQ0_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr0 && !reg_req_i.wdata[NFIU_BIT_SET_SEL] && reg_req_i.wdata[NFIU_BIT_TX_DONE]
		 && !events_i.tx_last_bit) |=> !q.req0[NFIU_BIT_TX_DONE])
		else $error("request zero clear failed");

	AST_GLOBAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(q.req1[NFIU_BIT_CARD] && q.en1[NFIU_BIT_CARD]) |-> global_o)
		else $error("global request not raised");

	AST_GLOBAL_REQ0: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(|(q.req0 & q.en0[6:0])) |-> global_o)
		else $error("enabled request zero flag not global");

	AST_GLOBAL_TIMER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(|(q.req1[4:0] & q.en1[4:0])) |-> global_o)
		else $error("enabled timer flag not global");

	AST_GLOBAL_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		((q.req0 & q.en0[6:0]) == 7'h00 && (q.req1 & q.en1[5:0]) == 6'h00) |-> !global_o)
		else $error("global request without enabled flag");

	AST_READ_GLOBAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(reg_req_i.rd && reg_req_i.addr == NFIU_ADDR_REQ1)
		|=> reg_rdata_o[NFIU_BIT_GLOBAL] == $past(global_o))
		else $error("global bit read back wrong");

	AST_CARD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.card_detect |=> q.req1[NFIU_BIT_CARD])
		else $error("card-detect flag missing");

	AST_TIMER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.timer_underflow[4] |=> q.req1[4])
		else $error("timer flag missing");

	AST_TIMER_ALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(events_i.timer_underflow != 5'h00)
		|=> ((q.req1[4:0] & $past(events_i.timer_underflow)) == $past(events_i.timer_underflow)))
		else $error("timer flag of some timer missing");

	AST_REQ1_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!wr1 && hw1 == 6'h00)
		|=> q.req1 == $past(q.req1))
		else $error("request one changed without cause");

	AST_EN0_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(reg_req_i.wr && reg_req_i.addr == NFIU_ADDR_EN0) |=> q.en0 == $past(reg_req_i.wdata))
		else $error("enable zero write lost");

	AST_EN1_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(reg_req_i.wr && reg_req_i.addr == NFIU_ADDR_EN1) |=> q.en1 == $past(reg_req_i.wdata))
		else $error("enable one write lost");

	AST_READ_EN0: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(reg_req_i.rd && reg_req_i.addr == NFIU_ADDR_EN0) |=> reg_rdata_o == $past(q.en0))
		else $error("enable zero read back wrong");

	AST_ALERT_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(q.req0[NFIU_BIT_HI_ALERT] && !wr0) |=> q.req0[NFIU_BIT_HI_ALERT])
		else $error("fifo alert flag dropped");

	AST_LO_ALERT_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(q.req0[NFIU_BIT_LO_ALERT] && !wr0) |=> q.req0[NFIU_BIT_LO_ALERT])
		else $error("fifo low alert flag dropped");

	AST_HI_ALERT_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.fifo_hi_alert |=> q.req0[NFIU_BIT_HI_ALERT])
		else $error("fifo high alert not latched");

	AST_LO_ALERT_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		events_i.fifo_lo_alert |=> q.req0[NFIU_BIT_LO_ALERT])
		else $error("fifo low alert not latched");

	AST_SET_WINS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr0 && !reg_req_i.wdata[NFIU_BIT_SET_SEL] && events_i.rx_end) |=> q.req0[NFIU_BIT_RX_DONE])
		else $error("hardware set lost to clear");

	AST_PIN_GATED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!q.en1[NFIU_BIT_PIN_EN] && q.en1[NFIU_BIT_PUSH_PULL])
		|=> irq_pin_o == $past(q.en0[NFIU_BIT_PIN_INV]))
		else $error("gated pin not at inactive level");

	AST_PIN_OD_GATED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!q.en1[NFIU_BIT_PIN_EN] && !q.en1[NFIU_BIT_PUSH_PULL])
		|=> irq_oe_n_o == $past(q.en0[NFIU_BIT_PIN_INV]) && !irq_pin_o)
		else $error("gated open-drain pin not at inactive level");

	AST_PIN_PP_DRIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		q.en1[NFIU_BIT_PUSH_PULL] |=> !irq_oe_n_o)
		else $error("push-pull pin not driven");

	AST_PIN_ACTIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(global_o && q.en1[NFIU_BIT_PIN_EN] && q.en1[NFIU_BIT_PUSH_PULL] && !q.en0[NFIU_BIT_PIN_INV])
		|=> irq_pin_o && !irq_oe_n_o)
		else $error("pin not active on enabled request");

	AST_PIN_INVERTED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(global_o && q.en1[NFIU_BIT_PIN_EN] && q.en1[NFIU_BIT_PUSH_PULL] && q.en0[NFIU_BIT_PIN_INV])
		|=> !irq_pin_o && !irq_oe_n_o)
		else $error("inverted pin not low on request");

	AST_PIN_OD_ACTIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(global_o && q.en1[NFIU_BIT_PIN_EN] && !q.en1[NFIU_BIT_PUSH_PULL] && !q.en0[NFIU_BIT_PIN_INV])
		|=> irq_oe_n_o && !irq_pin_o)
		else $error("open-drain pin not released on request");

endmodule

/* dv/nfiu_host_model.sv */
// host side of the interrupt pin: board pull-up and resolved wire level
// assumes the unit drives the pin only while its enable is low
module nfiu_host_model (
	input  wire logic irq_pin_i,   // unit pin value
	input  wire logic irq_oe_n_i,  // unit pin enable, low drives
	output logic      pin_level_o  // level the host sees
);
	timeunit 1ns;
	timeprecision 100ps;
	// released wire floats up to the pull-up level
	assign pin_level_o = irq_oe_n_i ? 1'b1 : irq_pin_i;
endmodule

/* dv/tb_top.sv */
// self-checking bench of the interrupt unit against a cycle-based reference model
// assumes the host model for the pin wire and the design package
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import nfiu_pkg::*;
	logic          sys_clk_i = 1'b0;
	logic          rst_i = 1'b1;
	nfiu_reg_req_s req = '0;
	nfiu_events_s  ev = '0;
	logic [7:0]    rdata, m_e0, m_e1, m_rd;
	logic          glob, pin, oe_n, wire_lvl, m_g, m_pin, m_oe;
	logic [6:0]    m_r0, n0;
	logic [5:0]    m_r1, n1;
	logic [4:0]    m_ep;
	int            fail_count = 0;
	int            num_checks = 0;
	integer        seed = 32'h4cf4;

	nfiu_irq_unit uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.events_i(ev), .global_o(glob), .irq_pin_o(pin), .irq_oe_n_o(oe_n));
	nfiu_host_model host (.irq_pin_i(pin), .irq_oe_n_i(oe_n), .pin_level_o(wire_lvl));

	initial forever #2.5 sys_clk_i = ~sys_clk_i;

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	always_comb m_g = |(m_r0 & m_e0[6:0]) | |(m_r1 & m_e1[5:0]);
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{m_r0, m_r1, m_e0, m_e1, m_rd, m_ep, m_pin, m_oe} <= '0;
		end else begin
			n0 = m_r0;
			n1 = m_r1;
			if (req.wr && req.addr == NFIU_ADDR_REQ0) n0 = req.wdata[7] ? n0 | req.wdata[6:0] : n0 & ~req.wdata[6:0];
			if (req.wr && req.addr == NFIU_ADDR_REQ1) n1 = req.wdata[7] ? n1 | req.wdata[5:0] : n1 & ~req.wdata[5:0];
			m_r0 <= n0 | {ev.fifo_hi_alert, ev.fifo_lo_alert, ev.cmd_self_end | ev.cmd_unknown, ev.tx_last_bit,
				ev.rx_end, |(ev.errors & ~m_ep), ev.sof_det | ev.subcarrier_det};
			m_r1 <= n1 | {ev.card_detect, ev.timer_underflow};
			if (req.wr && req.addr == NFIU_ADDR_EN0) m_e0 <= req.wdata;
			if (req.wr && req.addr == NFIU_ADDR_EN1) m_e1 <= req.wdata;
			m_ep <= ev.errors;
			if (req.rd) m_rd <= (req.addr == NFIU_ADDR_REQ0) ? {1'b0, m_r0} : (req.addr == NFIU_ADDR_REQ1) ?
				{1'b0, m_g, m_r1} : (req.addr == NFIU_ADDR_EN0) ? m_e0 : (req.addr == NFIU_ADDR_EN1) ? m_e1 : 8'h00;
			m_pin <= m_e1[7] ? (m_g & m_e1[6]) ^ m_e0[7] : 1'b0;
			m_oe  <= m_e1[7] ? 1'b0 : (m_g & m_e1[6]) ^ m_e0[7];
		end
	end

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	always @(negedge sys_clk_i) begin
		if (!rst_i) begin
			check(rdata, m_rd);
			check({7'h00, glob}, {7'h00, m_g});
			check({6'h00, pin, oe_n}, {6'h00, m_pin, m_oe});
			check({7'h00, wire_lvl}, {7'h00, m_oe | m_pin});
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic step(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d,
		input nfiu_events_s e);
		@(posedge sys_clk_i);
		#1;
		req.wr = wr;
		req.rd = rd;
		req.addr = a;
		req.wdata = d;
		ev = e;
	endtask

	initial begin
		#50000;
		fail_count++;
		close_out;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0]  op;
		nfiu_events_s e;
		repeat (20) @(posedge sys_clk_i);
		#1 rst_i = 1'b0;
		for (int a = 5; a < 11; a++) step(1'b0, 1'b1, 8'(a), 8'h00, '0);
		$display("test reset values done");
		for (int i = 0; i < 20; i++) begin
			step(1'b0, 1'b0, 8'h00, 8'h00, nfiu_events_s'(20'h1 << i));
			step(1'b0, 1'b1, NFIU_ADDR_REQ0, 8'h00, '0);
			step(1'b0, 1'b1, NFIU_ADDR_REQ1, 8'h00, '0);
			step(1'b1, 1'b0, NFIU_ADDR_REQ0, 8'h7F, '0);
			step(1'b1, 1'b0, NFIU_ADDR_REQ1, 8'h3F, '0);
		end
		$display("test event sources done");
		e = '0;
		e.tx_last_bit = 1'b1;
		step(1'b1, 1'b0, NFIU_ADDR_REQ0, 8'h7F, e);
		step(1'b0, 1'b1, NFIU_ADDR_REQ0, 8'h00, '0);
		step(1'b1, 1'b0, NFIU_ADDR_REQ0, 8'hFF, '0);
		step(1'b0, 1'b1, NFIU_ADDR_REQ0, 8'h00, '0);
		$display("test set against clear done");
		for (int m = 0; m < 4; m++) begin
			step(1'b1, 1'b0, NFIU_ADDR_EN0, {m[0], 7'h7F}, '0);
			step(1'b1, 1'b0, NFIU_ADDR_EN1, {m[1], 7'h7F}, '0);
			step(1'b1, 1'b0, NFIU_ADDR_REQ1, 8'h81, '0);
			step(1'b0, 1'b1, NFIU_ADDR_REQ1, 8'h00, '0);
			step(1'b1, 1'b0, NFIU_ADDR_EN1, {m[1], 7'h3F}, '0);
			step(1'b1, 1'b0, NFIU_ADDR_REQ1, 8'h01, '0);
			repeat (2) step(1'b0, 1'b0, 8'h00, 8'h00, '0);
		end
		$display("test pin modes done");
		for (int k = 0; k < 3000; k++) begin
			if (k == 1500) begin
				step(1'b0, 1'b0, 8'h00, 8'h00, '0);
				rst_i = 1'b1;
				repeat (2) @(posedge sys_clk_i);
				#1 rst_i = 1'b0;
			end
			op = $random(seed);
			e = nfiu_events_s'(20'($random(seed) & $random(seed) & $random(seed)));
			step(op[0] & op[1], op[0] & ~op[1], 8'h05 + 8'(op[4:2]), 8'($random(seed)), e);
		end
		step(1'b0, 1'b0, 8'h00, 8'h00, '0);
		$display("test random traffic done");
		close_out;
	end
endmodule
